// ### logic/tasl_top.sv
/*
 * Event, status and alert logic of a two-zone temperature supervisor,
 * with its byte-wide register map selected by command byte.
 * Assumes the serial front end and the converter sequencer run on
 * REF_CLK_I and hand over one-cycle strobes; open-drain pins are
 * resolved outside from the enables.
 */
// Contract
// - Zone event sets flag regardless of mask
// - Alert drives only while mask is clear
// - Any register read releases interrupt-mode alert
// - Config read clears zone flags after return
// - Re-arm only after crossing opposite threshold
// - Shutdown releases interrupt-mode alert, clears zone flags
// - Remote crossings set remote flag, alert
// - Local crossings set local flag, alert
// - Remote above critical threshold asserts critical
// - Remote below release deasserts critical
// - Critical ignores mask and mode
// - Critical flag mirrors output, read-safe
// - Critical holds through shutdown
// - Diode fault sets critical and remote
// - Event needs filter-depth consecutive conversions
// - Repeated events collapse into one flag
// - Results read zero until first conversion or remote write
// - Power-up overtemperature flagged after filter
// - Two-bit depth code selects 1,2,4,6
// - Comparator alert follows hysteresis, ignores shutdown
// - Values and compares signed eight bit
`timescale 1ns/1ns
`include "tasl_regs.svh"

module tasl_top
    import tasl_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RESET_N_I,
    // Register access from the serial front end
    input  wire logic [7:0] REG_CMD_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_RD_I,
    output logic      [7:0] REG_RDATA_O,
    output logic            REG_RVALID_O,
    // Converter results
    input  wire logic       CONV_DONE_I,
    input  wire logic       CONV_REMOTE_I,
    input  wire logic [7:0] CONV_TEMP_I,
    input  wire logic       DIODE_FAULT_I,
    output logic            POWER_DOWN_O,
    // Open-drain outputs, pulled low while enabled
    output logic            ALERT_OUT_O,
    output logic            ALERT_OE_O,
    output logic            CRITICAL_OUT_O,
    output logic            CRITICAL_OE_O
);

    // ============================================================
    // Register storage
    logic [7:0] local_temp_result;
    logic [7:0] remote_temp_result;
    tasl_thr_t  local_thr;
    tasl_thr_t  remote_thr;
    tasl_thr_t  critical_out_n_thr;
    tasl_cfg_t  cfg;
    logic       local_event_flag;
    logic       remote_event_flag;
    logic       alert_pending;

    tasl_zone_t local_zone;
    tasl_zone_t remote_zone;
    tasl_zone_t critical_out_n_zone;

    // ============================================================
    // Command decode
    logic sel_local_temp;
    logic sel_config;
    logic sel_local_hyst;
    logic sel_local_set;
    logic sel_remote_temp;
    logic sel_remote_hyst;
    logic sel_remote_set;
    logic sel_critical_out_n_release;
    logic sel_critical_out_n_thresh;
    logic sel_mapped;

    always_comb begin
        sel_local_temp   = 1'b0;
        sel_config       = 1'b0;
        sel_local_hyst   = 1'b0;
        sel_local_set    = 1'b0;
        sel_remote_temp  = 1'b0;
        sel_remote_hyst  = 1'b0;
        sel_remote_set   = 1'b0;
        sel_critical_out_n_release = 1'b0;
        sel_critical_out_n_thresh  = 1'b0;
        if (REG_CMD_I == `TASL_CMD_LOCAL_TEMP) begin
            sel_local_temp = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_CONFIG) begin
            sel_config = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_LOCAL_HYST) begin
            sel_local_hyst = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_LOCAL_SET) begin
            sel_local_set = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_REMOTE_TEMP) begin
            sel_remote_temp = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_REMOTE_HYST) begin
            sel_remote_hyst = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_REMOTE_SET) begin
            sel_remote_set = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_CRITICAL_OUT_N_RELEASE) begin
            sel_critical_out_n_release = 1'b1;
        end else if (REG_CMD_I == `TASL_CMD_CRITICAL_OUT_N_THRESH) begin
            sel_critical_out_n_thresh = 1'b1;
        end
    end

    assign sel_mapped = sel_local_temp | sel_config | sel_local_hyst | sel_local_set
                      | sel_remote_temp | sel_remote_hyst | sel_remote_set
                      | sel_critical_out_n_release | sel_critical_out_n_thresh;

    // ============================================================
    // Access strobes
    logic any_read;
    logic config_read;
    logic config_write;
    logic power_down_entry;
    logic sample_local;
    logic sample_remote;

    assign any_read         = REG_RD_I & sel_mapped;
    assign config_read      = REG_RD_I & sel_config;
    assign config_write     = REG_WR_I & sel_config;
    assign power_down_entry = config_write & REG_WDATA_I[`TASL_CFG_POWER_DOWN]
                            & ~cfg.power_down_bit;

    // No conversions are accepted while powered down
    assign sample_local  = CONV_DONE_I & ~CONV_REMOTE_I & ~cfg.power_down_bit;
    assign sample_remote = CONV_DONE_I &  CONV_REMOTE_I & ~cfg.power_down_bit;

    // ============================================================
    // Configuration fields
    localparam logic [7:0] CFG_RESET = `TASL_RST_CONFIG;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg <= tasl_cfg_t'(CFG_RESET[4:0]);
        end else if (config_write) begin
            cfg.event_filter_depth <= REG_WDATA_I[`TASL_CFG_DEPTH_HI:`TASL_CFG_DEPTH_LO];
            cfg.alert_mask         <= REG_WDATA_I[`TASL_CFG_MASK];
            cfg.mode               <= REG_WDATA_I[`TASL_CFG_MODE];
            cfg.power_down_bit     <= REG_WDATA_I[`TASL_CFG_POWER_DOWN];
        end
    end

    // ============================================================
    // Threshold registers
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            local_thr.lower  <= `TASL_RST_LOCAL_HYST;
            local_thr.upper  <= `TASL_RST_LOCAL_SET;
            remote_thr.lower <= `TASL_RST_REMOTE_HYST;
            remote_thr.upper <= `TASL_RST_REMOTE_SET;
            critical_out_n_thr.lower   <= `TASL_RST_CRITICAL_OUT_N_RELEASE;
            critical_out_n_thr.upper   <= `TASL_RST_CRITICAL_OUT_N_THRESH;
        end else if (REG_WR_I) begin
            if (sel_local_hyst) begin
                local_thr.lower <= REG_WDATA_I;
            end else if (sel_local_set) begin
                local_thr.upper <= REG_WDATA_I;
            end else if (sel_remote_hyst) begin
                remote_thr.lower <= REG_WDATA_I;
            end else if (sel_remote_set) begin
                remote_thr.upper <= REG_WDATA_I;
            end else if (sel_critical_out_n_release) begin
                critical_out_n_thr.lower <= REG_WDATA_I;
            end else if (sel_critical_out_n_thresh) begin
                critical_out_n_thr.upper <= REG_WDATA_I;
            end
        end
    end

    // ============================================================
    // Temperature results
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            local_temp_result <= `TASL_RST_TEMP;
        end else if (sample_local) begin
            local_temp_result <= CONV_TEMP_I;
        end
    end

    // Remote result is host-writable; a new conversion overrides it
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            remote_temp_result <= `TASL_RST_TEMP;
        end else if (sample_remote) begin
            remote_temp_result <= CONV_TEMP_I;
        end else if (REG_WR_I && sel_remote_temp) begin
            remote_temp_result <= REG_WDATA_I;
        end
    end

    // ============================================================
    // Zone and critical filters, fed the value being stored
    tasl_zone_filter u_local_filter (
        .clk_i        (REF_CLK_I),
        .reset_n_i    (RESET_N_I),
        .sample_i     (sample_local),
        .temp_i       (CONV_TEMP_I),
        .force_high_i (1'b0),
        .thr_i        (local_thr),
        .depth_i      (cfg.event_filter_depth),
        .zone_o       (local_zone)
    );

    tasl_zone_filter u_remote_filter (
        .clk_i        (REF_CLK_I),
        .reset_n_i    (RESET_N_I),
        .sample_i     (sample_remote),
        .temp_i       (CONV_TEMP_I),
        .force_high_i (DIODE_FAULT_I),
        .thr_i        (remote_thr),
        .depth_i      (cfg.event_filter_depth),
        .zone_o       (remote_zone)
    );

    tasl_zone_filter u_critical_out_n_filter (
        .clk_i        (REF_CLK_I),
        .reset_n_i    (RESET_N_I),
        .sample_i     (sample_remote),
        .temp_i       (CONV_TEMP_I),
        .force_high_i (DIODE_FAULT_I),
        .thr_i        (critical_out_n_thr),
        .depth_i      (cfg.event_filter_depth),
        .zone_o       (critical_out_n_zone)
    );

    // ============================================================
    // Zone status flags
    // Comparator mode flags heat only; interrupt mode flags both ways
    logic local_set;
    logic remote_set;
    logic flag_clear;

    assign local_set  = local_zone.high_event  | (cfg.mode & local_zone.low_event);
    assign remote_set = remote_zone.high_event | (cfg.mode & remote_zone.low_event);
    assign flag_clear = config_read | power_down_entry;

    // Set wins over a clear in the same cycle; no count is kept
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            local_event_flag <= 1'b0;
        end else if (local_set) begin
            local_event_flag <= 1'b1;
        end else if (flag_clear) begin
            local_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            remote_event_flag <= 1'b0;
        end else if (remote_set) begin
            remote_event_flag <= 1'b1;
        end else if (flag_clear) begin
            remote_event_flag <= 1'b0;
        end
    end

    // ============================================================
    // Alert: latched request in interrupt mode
    logic any_zone_event;
    logic alert_level;

    assign any_zone_event = local_zone.high_event | local_zone.low_event
                          | remote_zone.high_event | remote_zone.low_event;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            alert_pending <= 1'b0;
        end else if (cfg.mode && any_zone_event && !cfg.alert_mask) begin
            alert_pending <= 1'b1;
        end else if (any_read || power_down_entry || !cfg.mode) begin
            alert_pending <= 1'b0;
        end
    end

    // Comparator mode tracks the zone state, which shutdown leaves alone
    always_comb begin
        if (cfg.mode) begin
            // Mask also hides an alert latched before it was set
            alert_level = alert_pending & ~cfg.alert_mask;
        end else begin
            alert_level = ~cfg.alert_mask & (local_zone.over | remote_zone.over);
        end
    end

    // ============================================================
    // Read path: data is captured before the config read clears flags
    logic [7:0] read_mux;

    always_comb begin
        read_mux = `TASL_UNMAPPED_DATA;
        if (sel_local_temp) begin
            read_mux = local_temp_result;
        end else if (sel_config) begin
            read_mux = {local_event_flag, remote_event_flag, critical_out_n_zone.over,
                        cfg.event_filter_depth, cfg.alert_mask, cfg.mode,
                        cfg.power_down_bit};
        end else if (sel_local_hyst) begin
            read_mux = local_thr.lower;
        end else if (sel_local_set) begin
            read_mux = local_thr.upper;
        end else if (sel_remote_temp) begin
            read_mux = remote_temp_result;
        end else if (sel_remote_hyst) begin
            read_mux = remote_thr.lower;
        end else if (sel_remote_set) begin
            read_mux = remote_thr.upper;
        end else if (sel_critical_out_n_release) begin
            read_mux = critical_out_n_thr.lower;
        end else if (sel_critical_out_n_thresh) begin
            read_mux = critical_out_n_thr.upper;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            REG_RDATA_O  <= `TASL_UNMAPPED_DATA;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RVALID_O <= REG_RD_I;
            if (REG_RD_I) begin
                REG_RDATA_O <= read_mux;
            end
        end
    end

    // ============================================================
    // Pins
    // Critical path is independent of mask and mode by construction
    assign CRITICAL_OE_O  = critical_out_n_zone.over;
    assign CRITICAL_OUT_O = 1'b0;
    assign ALERT_OE_O     = alert_level;
    assign ALERT_OUT_O    = 1'b0;
    assign POWER_DOWN_O   = cfg.power_down_bit;

endmodule

// ### logic/tasl_zone_filter.sv
/*
 * One threshold pair with its consecutive-conversion filter and
 * high/low arming state; used per zone and for the critical function.
 * Assumes sample_i pulses once per completed conversion of its zone.
 */
`timescale 1ns/1ns
`include "tasl_regs.svh"

module tasl_zone_filter
    import tasl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       sample_i,
    input  wire logic [7:0] temp_i,
    input  wire logic       force_high_i,
    input  wire tasl_thr_t  thr_i,
    input  wire logic [1:0] depth_i,
    output tasl_zone_t      zone_o
);

    // ============================================================
    // Comparison and filtering
    logic       hi_cond;
    logic       lo_cond;
    logic [2:0] hi_cnt;
    logic [2:0] lo_cnt;
    logic [2:0] next_hi_cnt;
    logic [2:0] next_lo_cnt;
    logic [2:0] need;
    tasl_arm_t  arm;

    // Signed compares; a faulty diode counts as hot whatever it reads
    assign hi_cond = force_high_i | ($signed(temp_i) > $signed(thr_i.upper));
    assign lo_cond = ~force_high_i & ($signed(temp_i) < $signed(thr_i.lower));

    always_comb begin
        case (depth_i)
            `TASL_DEPTH_CODE_1: need = `TASL_DEPTH_COUNT_1;
            `TASL_DEPTH_CODE_2: need = `TASL_DEPTH_COUNT_2;
            `TASL_DEPTH_CODE_4: need = `TASL_DEPTH_COUNT_4;
            default:            need = `TASL_DEPTH_COUNT_6;
        endcase
    end

    assign next_hi_cnt = (hi_cnt == `TASL_COUNT_MAX) ? hi_cnt : hi_cnt + 3'h1;
    assign next_lo_cnt = (lo_cnt == `TASL_COUNT_MAX) ? lo_cnt : lo_cnt + 3'h1;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_cnt <= 3'h0;
            lo_cnt <= 3'h0;
        end else if (sample_i) begin
            hi_cnt <= hi_cond ? next_hi_cnt : 3'h0;
            lo_cnt <= lo_cond ? next_lo_cnt : 3'h0;
        end
    end

    // ============================================================
    // Arming: high armed from reset so power-up heat is caught
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            arm             <= TASL_ARM_HIGH;
            zone_o          <= '0;
        end else begin
            zone_o.high_event <= 1'b0;
            zone_o.low_event  <= 1'b0;
            if (sample_i) begin
                case (arm)
                    TASL_ARM_HIGH: begin
                        if (hi_cond && next_hi_cnt >= need) begin
                            arm               <= TASL_ARM_LOW;
                            zone_o.high_event <= 1'b1;
                            zone_o.over       <= 1'b1;
                        end
                    end
                    default: begin
                        if (lo_cond && next_lo_cnt >= need) begin
                            arm              <= TASL_ARM_HIGH;
                            zone_o.low_event <= 1'b1;
                            zone_o.over      <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

endmodule

// ### shared/tasl_pkg.sv
/*
 * Types shared by the thermal alert and status logic.
 * Assumes compilation before the design modules.
 */
package tasl_pkg;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic [1:0] event_filter_depth;
        logic       alert_mask;
        logic       mode;
        logic       power_down_bit;
    } tasl_cfg_t;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
    } tasl_thr_t;

    typedef struct packed {
        logic high_event;
        logic low_event;
        logic over;
    } tasl_zone_t;

    // ============================================================
    // Which threshold a zone is waiting to cross next
    typedef enum logic {
        TASL_ARM_HIGH,
        TASL_ARM_LOW
    } tasl_arm_t;

endpackage

// ### shared/tasl_regs.svh
/*
 * Register map, field positions, reset values and filter depths of the
 * thermal alert and status logic.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef TASL_REGS_SVH
`define TASL_REGS_SVH

// ============================================================
// Command byte values
`define TASL_CMD_LOCAL_TEMP     8'h00
`define TASL_CMD_CONFIG         8'h01
`define TASL_CMD_LOCAL_HYST     8'h02
`define TASL_CMD_LOCAL_SET      8'h03
`define TASL_CMD_REMOTE_TEMP    8'h10
`define TASL_CMD_REMOTE_HYST    8'h12
`define TASL_CMD_REMOTE_SET     8'h13
`define TASL_CMD_CRITICAL_OUT_N_RELEASE   8'h22
`define TASL_CMD_CRITICAL_OUT_N_THRESH    8'h23

// ============================================================
// Config and status field positions
`define TASL_CFG_LOCAL_FLAG     7
`define TASL_CFG_REMOTE_FLAG    6
`define TASL_CFG_CRITICAL_OUT_N_FLAG      5
`define TASL_CFG_DEPTH_HI       4
`define TASL_CFG_DEPTH_LO       3
`define TASL_CFG_MASK           2
`define TASL_CFG_MODE           1
`define TASL_CFG_POWER_DOWN     0

// ============================================================
// Reset values
`define TASL_RST_TEMP           8'h00
`define TASL_RST_CONFIG         8'h00
`define TASL_RST_LOCAL_HYST     8'h4C
`define TASL_RST_LOCAL_SET      8'h51
`define TASL_RST_REMOTE_HYST    8'h5C
`define TASL_RST_REMOTE_SET     8'h61
`define TASL_RST_CRITICAL_OUT_N_RELEASE   8'h5C
`define TASL_RST_CRITICAL_OUT_N_THRESH    8'h61
`define TASL_UNMAPPED_DATA      8'h00

// ============================================================
// Filter depth codes and conversion counts
`define TASL_DEPTH_CODE_1       2'h0
`define TASL_DEPTH_CODE_2       2'h1
`define TASL_DEPTH_CODE_4       2'h2
`define TASL_DEPTH_CODE_6       2'h3
`define TASL_DEPTH_COUNT_1      3'h1
`define TASL_DEPTH_COUNT_2      3'h2
`define TASL_DEPTH_COUNT_4      3'h4
`define TASL_DEPTH_COUNT_6      3'h6
`define TASL_COUNT_MAX          3'h7

`endif

// ### testbench/tasl_checker_assertions.sv
/* Port checker for tasl_top.
   Assumes one clock domain and a bind by name to the top module. */
`timescale 1ns/1ns
module tasl_checker (
    input wire logic       REF_CLK_I,
    input wire logic       RESET_N_I,
    input wire logic [7:0] REG_CMD_I,
    input wire logic       REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic       REG_RD_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic       REG_RVALID_O,
    input wire logic       CONV_DONE_I,
    input wire logic       CONV_REMOTE_I,
    input wire logic [7:0] CONV_TEMP_I,
    input wire logic       DIODE_FAULT_I,
    input wire logic       POWER_DOWN_O,
    input wire logic       ALERT_OE_O,
    input wire logic       CRITICAL_OE_O
);
    // ==========
    // Shadow copies of the host-written settings
    logic [7:0] cfg;
    logic [7:0] thr;
    logic [7:0] rel;
    logic       mapped;
    assign mapped = REG_CMD_I inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h12, 8'h13,
                                      8'h22, 8'h23};
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cfg <= 8'h00;
            thr <= 8'h61;
            rel <= 8'h5C;
        end else if (REG_WR_I) begin
            if (REG_CMD_I == 8'h01) cfg <= REG_WDATA_I;
            if (REG_CMD_I == 8'h23) thr <= REG_WDATA_I;
            if (REG_CMD_I == 8'h22) rel <= REG_WDATA_I;
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read not answered");
    a_unmapped_zero: assert property (REG_RVALID_O && !$past(mapped) |-> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    a_critical_out_n_mirror: assert property (REG_RVALID_O && $past(REG_CMD_I) == 8'h01
        |-> REG_RDATA_O[5] == $past(CRITICAL_OE_O)) else $error("critical bit differs from pin");
    a_mask_blocks: assert property (cfg[2] |-> !ALERT_OE_O)
        else $error("alert driven while masked");
    a_critical_out_n_hold_pd: assert property (POWER_DOWN_O && $past(POWER_DOWN_O)
        |-> $stable(CRITICAL_OE_O)) else $error("critical moved in shutdown");
    a_critical_out_n_rise: assert property ($rose(CRITICAL_OE_O) |-> $past(CONV_DONE_I && CONV_REMOTE_I)
        && ($past(DIODE_FAULT_I) || $signed($past(CONV_TEMP_I)) > $signed($past(thr))))
        else $error("critical rose without cause");
    a_critical_out_n_fall: assert property ($fell(CRITICAL_OE_O) |-> $past(CONV_DONE_I && CONV_REMOTE_I)
        && $signed($past(CONV_TEMP_I)) < $signed($past(rel)))
        else $error("critical fell without cause");
    a_read_release: assert property (cfg[1] && REG_RVALID_O && $past(mapped)
        && !$past(CONV_DONE_I, 2) |-> !ALERT_OE_O) else $error("read left alert asserted");
endmodule
bind tasl_top tasl_checker i_checker (.*);

// ### testbench/tasl_host_model.sv
/* Serial host model: byte register reads and writes by command byte.
   Assumes the front end hands over one-cycle strobes on the clock. */
`timescale 1ns/1ns
module tasl_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic      [7:0] cmd_o = 8'h00,
    output logic            wr_o = 1'b0,
    output logic      [7:0] wdata_o = 8'h00,
    output logic            rd_o = 1'b0
);
    // ==========
    // Released lines show the inverse so stale bytes never look valid
    task automatic wr(input logic [7:0] c, input logic [7:0] dat);
        @(posedge clk_i);
        cmd_o   <= c;
        wdata_o <= dat;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        cmd_o   <= ~c;
        wdata_o <= ~dat;
        #1;
    endtask
    task automatic rd(input logic [7:0] c, output logic [7:0] dat, output logic ok);
        @(posedge clk_i);
        cmd_o <= c;
        rd_o  <= 1'b1;
        @(posedge clk_i);
        rd_o  <= 1'b0;
        cmd_o <= ~c;
        #1;
        dat = rdata_i;
        ok  = rvalid_i;
    endtask
endmodule

// ### testbench/thermal_alert_status_logic_bench.sv
/* Self-checking bench for the thermal alert and status logic.
   Assumes the host model and bound checker are compiled before it. */
`timescale 1ns/1ns
module thermal_alert_status_logic_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       done = 1'b0;
    logic       remote = 1'b0;
    logic       fault = 1'b0;
    logic [7:0] temp = 8'h00;
    logic [7:0] cmd, wdata, rdata, d;
    logic       wr, rd, rvalid, pd, alert, critical_out_n, v, ao, co;
    int         error_cnt = 0;
    int         num_checks = 0;
    int         n [4] = '{1, 2, 4, 6};
    logic [7:0] cmds [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10,
                              8'h12, 8'h13, 8'h22, 8'h23, 8'h05};
    logic [7:0] rsts [10] = '{8'h00, 8'h00, 8'h4C, 8'h51, 8'h00,
                              8'h5C, 8'h61, 8'h5C, 8'h61, 8'h00};
    always #10 clk = ~clk;
    tasl_top i_dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .REG_CMD_I(cmd), .REG_WR_I(wr),
        .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .CONV_DONE_I(done), .CONV_REMOTE_I(remote), .CONV_TEMP_I(temp),
        .DIODE_FAULT_I(fault), .POWER_DOWN_O(pd), .ALERT_OUT_O(ao), .ALERT_OE_O(alert),
        .CRITICAL_OUT_O(co), .CRITICAL_OE_O(critical_out_n));
    tasl_host_model i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .cmd_o(cmd),
        .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    // ==========
    // Checking helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] c, input logic [7:0] exp);
        i_host.rd(c, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask
    task automatic outs(input logic [1:0] exp);
        chk({4'h0, ao, co, alert, critical_out_n}, {6'h00, exp});
    endtask
    // One conversion; returns once flags and alert have settled
    task automatic cv(input logic r, input logic [7:0] t, input logic f);
        @(posedge clk);
        done   <= 1'b1;
        remote <= r;
        temp   <= t;
        fault  <= f;
        @(posedge clk);
        done   <= 1'b0;
        temp   <= ~t;
        fault  <= ~f;
        @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    // ==========
    // Scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        foreach (cmds[i]) rchk(cmds[i], rsts[i]);
        i_host.wr(8'h00, 8'h55);
        rchk(8'h00, 8'h00);
        i_host.wr(8'h03, 8'h50);
        rchk(8'h03, 8'h50);
        i_host.wr(8'h10, 8'h3C);
        rchk(8'h10, 8'h3C);
        cv(1'b0, 8'hD8, 1'b0);
        outs(2'b00);
        rchk(8'h00, 8'hD8);
        cv(1'b0, 8'h52, 1'b0);
        outs(2'b10);
        rchk(8'h01, 8'h80);
        rchk(8'h01, 8'h00);
        outs(2'b10);
        cv(1'b0, 8'h4B, 1'b0);
        outs(2'b00);
        cv(1'b0, 8'h52, 1'b0);
        cv(1'b0, 8'h4B, 1'b0);
        cv(1'b0, 8'h52, 1'b0);
        rchk(8'h01, 8'h80);
        rchk(8'h01, 8'h00);
        i_host.wr(8'h01, 8'h06);
        outs(2'b00);
        cv(1'b1, 8'h62, 1'b0);
        outs(2'b01);
        rchk(8'h01, 8'h66);
        rchk(8'h01, 8'h26);
        i_host.wr(8'h01, 8'h02);
        cv(1'b1, 8'h63, 1'b0);
        outs(2'b01);
        cv(1'b1, 8'h5B, 1'b0);
        outs(2'b10);
        rchk(8'h10, 8'h5B);
        outs(2'b00);
        rchk(8'h01, 8'h42);
        cv(1'b0, 8'h4B, 1'b0);
        cv(1'b1, 8'h62, 1'b0);
        outs(2'b11);
        i_host.wr(8'h01, 8'h03);
        outs(2'b01);
        chk({7'h00, pd}, 8'h01);
        rchk(8'h01, 8'h23);
        cv(1'b1, 8'h50, 1'b0);
        outs(2'b01);
        rchk(8'h10, 8'h62);
        i_host.wr(8'h01, 8'h00);
        cv(1'b1, 8'h50, 1'b0);
        outs(2'b00);
        // Filter depth per code; a miss in mid-count restarts the count
        for (int k = 0; k < 4; k++) begin
            i_host.wr(8'h01, {3'h0, k[1:0], 3'h0});
            repeat (n[k] - 1) cv(1'b1, 8'h62, 1'b0);
            cv(1'b1, 8'h50, 1'b0);
            repeat (n[k] - 1) cv(1'b1, 8'h62, 1'b0);
            outs(2'b00);
            cv(1'b1, 8'h62, 1'b0);
            outs(2'b11);
            repeat (n[k] - 1) cv(1'b1, 8'h50, 1'b0);
            outs(2'b11);
            cv(1'b1, 8'h50, 1'b0);
            outs(2'b00);
        end
        i_host.wr(8'h01, 8'h00);
        cv(1'b1, 8'h50, 1'b1);
        outs(2'b11);
        rchk(8'h01, 8'h60);
        test_done();
    end
endmodule
